// >>> core/psrs_pkg.sv
package psrs_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PIX_PERIOD_NS = 100;
    localparam int DIV_CYCLES    = PIX_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_HALF      = DIV_CYCLES / 2;
    localparam int LAT_TICKS     = 4;
    localparam logic [3:0] DIV_LAST   = 4'(DIV_CYCLES - 1);
    localparam logic [3:0] DIV_HIGH   = 4'(DIV_HALF);
    localparam logic [3:0] SER_LAST   = 4'(DIV_CYCLES - 1);
    localparam logic [2:0] LAT_LAST   = 3'(LAT_TICKS - 1);

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int DAC_COUNT = 14;
    localparam int DAC_BITS  = 8;
    localparam int BIAS_BITS = DAC_COUNT * DAC_BITS;
    localparam int COL_BITS  = 128;
    localparam int CFG_BITS  = 6;
    localparam logic [6:0] ROW_FIRST = 7'h7F;
    localparam logic [6:0] ROW_LAST  = 7'h00;
    localparam logic [6:0] SLOT_LAST = 7'h41;
    localparam int DAC_TEST_ONE  = 11;
    localparam int DAC_TEST_ZERO = 10;
    localparam int WORD_BITS = 20;

    // ------------------------------------------------------------------
    // Configuration fields and reset values
    // ------------------------------------------------------------------
    localparam int CFG_TEST_BIT   = 0;
    localparam int CFG_PAR_BIT    = 2;
    localparam int CFG_STROBE_BIT = 4;
    localparam logic [CFG_BITS-1:0]  CFG_RST    = 6'h14;
    localparam logic [BIAS_BITS-1:0] BIAS_RST   = '0;
    localparam logic [COL_BITS-1:0]  COLDIS_RST = '0;
    // Identification instruction code; the value is arbitrary.
    localparam logic [4:0] INSTR_IDENT = 5'h01;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ALIGN = 2'b01,
        ST_LAT   = 2'b10,
        ST_SCAN  = 2'b11
    } psrs_state_t;

    typedef enum logic [2:0] {
        SRC_PIX       = 3'b000,
        SRC_REF_HIGH  = 3'b001,
        SRC_REF_LOW   = 3'b010,
        SRC_TEST_ONE  = 3'b011,
        SRC_TEST_ZERO = 3'b100,
        SRC_FIXED     = 3'b101
    } psrs_src_t;
endpackage

// >>> core/psrs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Reset clears all bias DAC codes to zero, the lowest power setting.
// - Reset clears the column disable mask so every column source is usable.
// - Reset loads the readout configuration with binary 10100.
// - Reset puts the test port in its reset state with identification selected.
// - Bias register is fourteen 8-bit DAC codes, 1 uA step each.
// - A 10 MHz pixel rate clock is driven, the input clock divided by ten.
// - Readout begins on the first pixel tick after frame align drops.
// - A reset marker pulse confirms the readout logic was reset.
// - A start marker shows that frame readout has begun.
// - First pixel appears four pixel ticks after frame align is sampled low.
// - With strobe bit clear, strobe marks only the first pixel of first frame.
// - With strobe bit set, strobe marks every pixel change at 10 MHz.
// - In serial mode each strobe period covers all ten subframe slots.
// - Row end flag is high while the last column of a row is selected.
// - Frame end flag is high while the last row is selected.
// - A 5 MHz monitor output toggles while clock enable is high, and holds while it is low.
// - Frames repeat back to back; frame align resynchronises at any time.
// - Four formats: normal or test, each serial or parallel.
// - Both subframes scan together, row by row, left to right.
// - Each row holds two reference pixels then 64 active pixels.
// - Scan runs from row 127 column 63 down to row 0 column 0.
// - Parallel: each subframe output gives ref high, ref low, columns 63 to 0.
// - Configuration bit 2 set selects parallel, clear selects serial.
// - Serial: one pixel per real subframe, then eight fixed values.
// - Test mode replaces pixels with two levels repeating one, zero, zero, one by slot.
module psrs_sequencer
    import psrs_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    input  wire logic                 bias_load,
    input  wire logic [BIAS_BITS-1:0] bias_data,
    input  wire logic                 cfg_load,
    input  wire logic [CFG_BITS-1:0]  cfg_data,
    input  wire logic                 coldis_load,
    input  wire logic [COL_BITS-1:0]  coldis_data,
    input  wire logic                 frame_align,
    input  wire logic                 pix_ready,
    output logic [BIAS_BITS-1:0]      bias_dac_codes,
    output logic [DAC_BITS-1:0]       test_level_one,
    output logic [DAC_BITS-1:0]       test_level_zero,
    output logic [CFG_BITS-1:0]       readout_config,
    output logic [COL_BITS-1:0]       column_disable_mask,
    output logic                      tap_in_reset,
    output logic [4:0]                tap_instruction,
    output logic                      pixel_rate_clock_out,
    output logic                      internal_clock_monitor,
    output logic                      readout_reset_marker,
    output logic                      start_marker,
    output logic                      pixel_strobe,
    output logic                      row_end_flag,
    output logic                      frame_end_flag,
    output logic                      pix_valid,
    output logic [6:0]                pix_row,
    output logic [6:0]                pix_slot,
    output logic [2:0]                sf1_src,
    output logic [2:0]                sf0_src,
    output logic                      serial_active,
    output logic [3:0]                serial_slot,
    output logic [2:0]                serial_src
);
    // ------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------
    logic [BIAS_BITS-1:0] bias_reg;
    logic [CFG_BITS-1:0]  cfg_reg;
    logic [COL_BITS-1:0]  coldis_reg;
    logic                 tap_tlr_reg;
    logic [4:0]           tap_ir_reg;
    logic [DAC_BITS-1:0]  dac_code [DAC_COUNT];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bias_reg    <= BIAS_RST;
            coldis_reg  <= COLDIS_RST;
            cfg_reg     <= CFG_RST;
            tap_tlr_reg <= 1'b1;
            tap_ir_reg  <= INSTR_IDENT;
        end else if (ce) begin
            if (bias_load) begin
                bias_reg <= bias_data;
            end
            if (cfg_load) begin
                cfg_reg <= cfg_data;
            end
            if (coldis_load) begin
                coldis_reg <= coldis_data;
            end
        end
    end

    // Bias register viewed as fourteen 8-bit DAC codes.
    genvar gi;
    generate
        for (gi = 0; gi < DAC_COUNT; gi++) begin : g_dac
            assign dac_code[gi] = bias_reg[gi*DAC_BITS +: DAC_BITS];
        end
    endgenerate

    wire cfg_test   = cfg_reg[CFG_TEST_BIT];
    wire cfg_par    = cfg_reg[CFG_PAR_BIT];
    wire cfg_strobe = cfg_reg[CFG_STROBE_BIT];

    // ------------------------------------------------------------------
    // Pixel rate divider and clock outputs
    // ------------------------------------------------------------------
    logic [3:0] div_reg;
    logic       pclk_reg;
    logic       mon_reg;
    wire        tick     = (div_reg == DIV_LAST);
    wire [3:0]  div_next = tick ? 4'h0 : div_reg + 4'h1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_reg  <= 4'h0;
            // Phase zero lies in the high half, so the first period after reset is whole.
            pclk_reg <= 1'b1;
            mon_reg  <= 1'b0;
        end else if (ce) begin
            div_reg  <= div_next;
            pclk_reg <= (div_next < DIV_HIGH);
            mon_reg  <= tick ? !mon_reg : mon_reg;
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    psrs_state_t state_reg;
    psrs_state_t state_next;
    logic [2:0]  lat_reg;
    logic [6:0]  row_reg;
    logic [6:0]  slot_reg;
    logic        buf_in_ready;

    wire lat_done = (state_reg == ST_LAT) && (lat_reg == LAT_LAST);
    wire align_go = tick && (state_reg == ST_ALIGN) && !frame_align;
    wire emit     = tick && !frame_align && buf_in_ready &&
                    ((state_reg == ST_SCAN) || lat_done);
    wire row_done = (slot_reg == SLOT_LAST);
    wire [6:0] slot_next = row_done ? 7'h00 : slot_reg + 7'h01;
    wire [6:0] row_step  = (row_reg == ROW_LAST) ? ROW_FIRST
                                                 : row_reg - 7'h01;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  state_next = ST_IDLE;
            ST_ALIGN: state_next = frame_align ? ST_ALIGN : ST_LAT;
            ST_LAT:   state_next = lat_done ? ST_SCAN : ST_LAT;
            ST_SCAN:  state_next = ST_SCAN;
            default:  state_next = ST_IDLE;
        endcase
        if (frame_align) begin
            state_next = ST_ALIGN;
        end
        if (lat_done && !emit && !frame_align) begin
            state_next = ST_LAT;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            lat_reg   <= 3'h0;
            row_reg   <= ROW_FIRST;
            slot_reg  <= 7'h00;
        end else if (ce && tick) begin
            state_reg <= state_next;
            if (frame_align) begin
                lat_reg  <= 3'h0;
                row_reg  <= ROW_FIRST;
                slot_reg <= 7'h00;
            end else if (state_reg == ST_LAT && !lat_done) begin
                lat_reg <= lat_reg + 3'h1;
            end
            if (emit) begin
                slot_reg <= slot_next;
                row_reg  <= row_done ? row_step : row_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pixel source selection
    // ------------------------------------------------------------------
    function automatic logic [2:0] src_of(input logic test, input logic [6:0] slot,
                                          input logic flip);
        logic alt;
        alt = slot[1] ^ slot[0] ^ flip;
        if (test) begin
            src_of = alt ? SRC_TEST_ZERO : SRC_TEST_ONE;
        end else if (slot == 7'h00) begin
            src_of = SRC_REF_HIGH;
        end else if (slot == 7'h01) begin
            src_of = SRC_REF_LOW;
        end else begin
            src_of = SRC_PIX;
        end
    endfunction

    wire [2:0] src1_now = src_of(cfg_test, slot_reg, 1'b0);
    wire [2:0] src0_now = src_of(cfg_test, slot_reg, 1'b1);
    wire [WORD_BITS-1:0] word_in = {row_reg, slot_reg, src1_now, src0_now};

    // ------------------------------------------------------------------
    // Markers
    // ------------------------------------------------------------------
    logic rrm_reg;
    logic start_reg;
    logic strobe_reg;
    logic first_frame_reg;
    logic row_end_reg;
    logic frame_end_reg;
    wire  first_pix = (row_reg == ROW_FIRST) && (slot_reg == 7'h00);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rrm_reg         <= 1'b0;
            start_reg       <= 1'b0;
            strobe_reg      <= 1'b0;
            first_frame_reg <= 1'b1;
            row_end_reg     <= 1'b0;
            frame_end_reg   <= 1'b0;
        end else if (ce) begin
            if (tick) begin
                rrm_reg <= align_go;
            end
            if (emit) begin
                start_reg     <= first_pix;
                row_end_reg   <= row_done;
                frame_end_reg <= (row_reg == ROW_LAST);
                if (cfg_strobe) begin
                    strobe_reg <= 1'b1;
                end else begin
                    strobe_reg <= first_pix && first_frame_reg;
                end
                if (first_pix) begin
                    first_frame_reg <= 1'b0;
                end
            end else if (cfg_strobe && div_reg == DIV_HIGH - 4'h1) begin
                strobe_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial slot stream
    // ------------------------------------------------------------------
    logic       ser_act_reg;
    logic [3:0] ser_slot_reg;
    logic [2:0] ser_src_reg;
    logic [2:0] cur_src0_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ser_act_reg  <= 1'b0;
            ser_slot_reg <= 4'h0;
            ser_src_reg  <= SRC_FIXED;
            cur_src0_reg <= SRC_FIXED;
        end else if (ce) begin
            if (emit) begin
                ser_act_reg  <= !cfg_par;
                ser_slot_reg <= 4'h0;
                ser_src_reg  <= src1_now;
                cur_src0_reg <= src0_now;
            end else begin
                if (ser_slot_reg != SER_LAST) begin
                    ser_slot_reg <= ser_slot_reg + 4'h1;
                end
                ser_src_reg <= (ser_slot_reg == 4'h0) ? cur_src0_reg : SRC_FIXED;
            end
        end
    end

    // ------------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------------
    logic                 h_valid_reg;
    logic                 s_valid_reg;
    logic [WORD_BITS-1:0] h_word_reg;
    logic [WORD_BITS-1:0] s_word_reg;
    wire                  h_take = !h_valid_reg || pix_ready;

    assign buf_in_ready = !s_valid_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            h_valid_reg <= 1'b0;
            s_valid_reg <= 1'b0;
            h_word_reg  <= '0;
            s_word_reg  <= '0;
        end else if (ce) begin
            if (h_take) begin
                if (s_valid_reg) begin
                    h_word_reg  <= s_word_reg;
                    s_valid_reg <= 1'b0;
                end else begin
                    h_valid_reg <= emit;
                    h_word_reg  <= emit ? word_in : h_word_reg;
                end
            end else if (emit) begin
                s_word_reg  <= word_in;
                s_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bias_dac_codes         = bias_reg;
    assign test_level_one         = dac_code[DAC_TEST_ONE];
    assign test_level_zero        = dac_code[DAC_TEST_ZERO];
    assign readout_config         = cfg_reg;
    assign column_disable_mask    = coldis_reg;
    assign tap_in_reset           = tap_tlr_reg;
    assign tap_instruction        = tap_ir_reg;
    assign pixel_rate_clock_out   = pclk_reg;
    assign internal_clock_monitor = mon_reg;
    assign readout_reset_marker   = rrm_reg;
    assign start_marker           = start_reg;
    assign pixel_strobe           = strobe_reg;
    assign row_end_flag           = row_end_reg;
    assign frame_end_flag         = frame_end_reg;
    assign pix_valid              = h_valid_reg;
    assign pix_row                = h_word_reg[19:13];
    assign pix_slot               = h_word_reg[12:6];
    assign sf1_src                = h_word_reg[5:3];
    assign sf0_src                = h_word_reg[2:0];
    assign serial_active          = ser_act_reg;
    assign serial_slot            = ser_slot_reg;
    assign serial_src             = ser_src_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b || !ce);

    a_bias_reset_zero: assert property ($rose(rst_b) |-> bias_reg == BIAS_RST)
        else $error("bias codes not zero after reset");
    a_coldis_reset_zero: assert property ($rose(rst_b) |-> coldis_reg == '0)
        else $error("column mask not zero after reset");
    a_cfg_reset_value: assert property ($rose(rst_b) |-> cfg_reg == 6'h14)
        else $error("readout configuration wrong after reset");
    a_pclk_period: assert property ($rose(pclk_reg) |-> ##10 $rose(pclk_reg))
        else $error("pixel rate clock period is not ten cycles");
    a_marker_pulse: assert property ($rose(rrm_reg) |-> rrm_reg[*8] ##1 rrm_reg[*2] ##1 !rrm_reg)
        else $error("reset marker width wrong");
    a_first_latency: assert property (@(posedge clk_sys)
        disable iff (!rst_b || !ce || frame_align || s_valid_reg)
        $rose(rrm_reg) |-> ##40 start_reg)
        else $error("first pixel not four ticks after align");
    a_strobe_width: assert property (cfg_strobe && $rose(strobe_reg) && !cfg_load
        |-> strobe_reg[*5] ##1 !strobe_reg)
        else $error("strobe width not half a pixel period");
    a_row_end_col: assert property ($rose(row_end_reg) |-> $past(slot_reg) == SLOT_LAST)
        else $error("row end flag not on last column");
    a_frame_end_row: assert property ($rose(frame_end_reg) |-> $past(row_reg) == ROW_LAST)
        else $error("frame end flag not on last row");
    a_scan_wrap: assert property (emit && row_reg == ROW_LAST && row_done
        |=> row_reg == ROW_FIRST && slot_reg == 7'h00)
        else $error("scan did not wrap to first row");
    a_serial_fixed: assert property (ser_slot_reg >= 4'h2 |-> ser_src_reg == SRC_FIXED)
        else $error("serial dummy slot not fixed value");

    c_frame_wrap: cover property (emit && row_reg == ROW_LAST && row_done);
    c_resync: cover property (state_reg == ST_SCAN && tick && frame_align);
    c_serial_emit: cover property (emit && !cfg_par);
    c_buffer_full: cover property (s_valid_reg && !pix_ready);
endmodule
`default_nettype wire

// >>> test/psrs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Readout controller model: takes pixel words, stalling at random
// ------------------------------------------------------------------
module psrs_ctrl_model (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic stall,
    output logic      pix_ready
);
    int seed = 32'h0000_0505;

    // Ready moves only just after an edge, so the sequencer sees it settled.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pix_ready <= 1'b0;
        end else begin
            pix_ready <= #1 !stall && (($random(seed) & 3) != 0);
        end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import psrs_pkg::*;
    logic clk_sys, rst_b, bias_load, cfg_load, coldis_load, frame_align, pix_ready, stall;
    logic [BIAS_BITS-1:0] bias_data, bias_dac_codes, b;
    logic [CFG_BITS-1:0]  cfg_data, readout_config, c;
    logic [COL_BITS-1:0]  coldis_data, column_disable_mask, m;
    logic [7:0] test_level_one, test_level_zero;
    logic [6:0] pix_row, pix_slot, exp_row, exp_slot;
    logic [4:0] tap_instruction;
    logic [3:0] serial_slot;
    logic [2:0] sf1_src, sf0_src, serial_src;
    logic tap_in_reset, pixel_rate_clock_out, internal_clock_monitor, readout_reset_marker;
    logic start_marker, pixel_strobe, row_end_flag, frame_end_flag, pix_valid, serial_active;
    logic scan_on, ce;
    logic [6:0]  rows_seen;
    logic [15:0] snap;
    int   error_cnt, checks, words, cyc;
    int   seed = 32'h0000_0404;
    time  t0;

    psrs_sequencer dut_u (.clk_sys, .rst_b, .ce, .bias_load, .bias_data, .cfg_load,
        .cfg_data, .coldis_load, .coldis_data, .frame_align, .pix_ready, .bias_dac_codes,
        .test_level_one, .test_level_zero, .readout_config, .column_disable_mask, .tap_in_reset,
        .tap_instruction, .pixel_rate_clock_out, .internal_clock_monitor, .readout_reset_marker,
        .start_marker, .pixel_strobe, .row_end_flag, .frame_end_flag, .pix_valid, .pix_row,
        .pix_slot, .sf1_src, .sf0_src, .serial_active, .serial_slot, .serial_src);
    psrs_ctrl_model ctrl_u (.clk_sys, .rst_b, .stall, .pix_ready);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Test mode: left output gives one, zero, zero, one by slot; right output the inverse.
    function automatic logic [2:0] exp_src(input logic [6:0] slot, input logic right);
        if (c[CFG_TEST_BIT]) begin
            return ((slot[1:0] == 2'h0 || slot[1:0] == 2'h3) ^ right) ? SRC_TEST_ONE
                                                                       : SRC_TEST_ZERO;
        end
        return (slot == 0) ? SRC_REF_HIGH : (slot == 1) ? SRC_REF_LOW : SRC_PIX;
    endfunction

    // Every accepted word must follow the scan order without loss.
    always @(posedge clk_sys) begin
        cyc++;
        if (scan_on && pix_valid === 1'b1 && pix_ready === 1'b1) begin
            chk(pix_row, exp_row, "row");
            chk(pix_slot, exp_slot, "slot");
            chk(sf1_src, exp_src(exp_slot, 1'b0), "left source");
            chk(sf0_src, exp_src(exp_slot, 1'b1), "right source");
            words++;
            exp_row = (exp_slot == SLOT_LAST) ? exp_row - 7'h01 : exp_row;
            exp_slot = (exp_slot == SLOT_LAST) ? 7'h00 : exp_slot + 7'h01;
        end
        if (cyc == 95000) begin
            error_cnt++;
            $display("[ERR] %0t run did not finish in time", $time);
            give_verdict();
        end
    end

    // At each row end: frame flag, strobe mode and the serial slot stream of the last column.
    always @(posedge row_end_flag) begin
        #1 chk(frame_end_flag, rows_seen == 7'h7F, "frame end flag");
        chk(pixel_strobe, c[CFG_STROBE_BIT], "pixel strobe");
        chk(serial_active, !c[CFG_PAR_BIT], "serial mode");
        rows_seen++;
        if (!c[CFG_PAR_BIT]) begin
            chk({serial_slot, serial_src}, {4'h0, exp_src(SLOT_LAST, 1'b0)}, "serial left");
            @(posedge clk_sys);
            #1 chk({serial_slot, serial_src}, {4'h1, exp_src(SLOT_LAST, 1'b1)}, "serial right");
            repeat (8) @(posedge clk_sys);
            #1 chk({serial_slot, serial_src}, {4'h9, SRC_FIXED}, "serial dummies");
        end
    end

    task automatic run_frame(input int rows, input logic [CFG_BITS-1:0] cfg);
        int n;
        @(posedge clk_sys);
        #1 frame_align = 1'b1;
        repeat (29) @(posedge clk_sys);
        #1 {cfg_data, cfg_load} = {cfg, 1'b1};
        @(posedge clk_sys);
        #1 {frame_align, cfg_load} = 2'b00;
        c = cfg;
        exp_row = ROW_FIRST;
        exp_slot = 7'h00;
        rows_seen = 7'h00;
        words = 0;
        scan_on = 1'b1;
        n = 0;
        while (readout_reset_marker !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(n < 100, 1, "reset marker");
        n = 0;
        while (pix_valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(n, 40, "first word latency");
        chk(start_marker, 1, "start marker");
        while (words < rows * 66 + 2) @(posedge clk_sys);
        $display("frame test done");
    endtask

    initial begin
        {bias_load, cfg_load, coldis_load, frame_align, stall, scan_on} = '0;
        {bias_data, cfg_data, coldis_data} = '0;
        ce = 1'b1;
        rst_b = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        chk(bias_dac_codes, 0, "bias after reset");
        chk(column_disable_mask, 0, "mask after reset");
        chk(readout_config, 6'h14, "config after reset");
        chk({tap_in_reset, tap_instruction}, {1'b1, INSTR_IDENT}, "test port");
        for (int i = 0; i < DAC_COUNT; i++) b[i*8 +: 8] = 8'($random(seed));
        b[111:96] = 16'h641E;
        c = (6'($random(seed)) & 6'h2A) | 6'h14;
        m = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {bias_data, cfg_data, coldis_data} = {b, c, m};
        {bias_load, cfg_load, coldis_load} = 3'b111;
        @(posedge clk_sys);
        #1 {bias_load, cfg_load, coldis_load} = 3'b000;
        chk(bias_dac_codes, b, "bias codes");
        chk({test_level_one, test_level_zero}, b[95:80], "test levels");
        chk({readout_config, column_disable_mask}, {c, m}, "config and mask");
        $display("load test done");
        @(posedge pixel_rate_clock_out);
        t0 = $time;
        @(posedge pixel_rate_clock_out);
        chk($time - t0, 100, "pixel clock period");
        @(posedge internal_clock_monitor);
        t0 = $time;
        @(posedge internal_clock_monitor);
        chk($time - t0, 200, "monitor period");
        run_frame(1, c);
        #1 stall = 1'b1;
        repeat (400) @(posedge clk_sys);
        #1 chk(pix_valid, 1, "word held while stalled");
        ce = 1'b0;
        snap = {pix_row, pix_slot, pixel_rate_clock_out, internal_clock_monitor};
        repeat (37) @(posedge clk_sys);
        #1 chk({pix_row, pix_slot, pixel_rate_clock_out, internal_clock_monitor}, snap, "frozen");
        {ce, stall} = 2'b10;
        while (words < 2 * 66) @(posedge clk_sys);
        $display("stall test done");
        run_frame(128, (6'($random(seed)) & 6'h2A) | 6'h01);
        give_verdict();
    end
endmodule
`default_nettype wire
